// file: hw/dps_switch.sv
// reservation and selection switch between two controller ports and one drive
`timescale 1ns/1ns
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module dps_switch (
    input  wire logic                             clk,
    input  wire logic                             rst_b,
    input  wire dps_pkg::dps_port_in_s [1:0]      port_in,
    output dps_pkg::dps_port_out_s     [1:0]      port_out,
    input  wire logic [1:0]                       ovr_sw,
    output logic [dps_pkg::ADDR_W-1:0]            drv_addr,
    output logic                                  drv_sel_en,
    input  wire logic                             drv_selected,
    input  wire logic                             hsel,
    input  wire logic [31:0]                      haddr,
    input  wire logic [1:0]                       htrans,
    input  wire logic                             hwrite,
    input  wire logic [2:0]                       hsize,
    input  wire logic [31:0]                      hwdata,
    input  wire logic                             hready,
    output logic                                  hreadyout,
    output logic                                  hresp,
    output logic [31:0]                           hrdata
);
    import dps_pkg::*;

    localparam int CNT_W = $clog2(REL_MIN_CYC + 1);
    localparam int WT_W  = $clog2(SEL_WAIT_CYC + 1);

    dps_port_in_s [1:0] pin;
    dps_ovr_e           ovr;
    logic               drv_sel;
    logic [1:0]         ovr_raw;
    dps_variant_e       variant;
    dps_state_e         st_q;
    logic               cur_q;
    logic               last_win_q;
    logic [ADDR_W-1:0]  plug_q;
    logic [WT_W-1:0]    wait_q;
    logic [CNT_W-1:0]   rel_cnt_q [2];
    logic [1:0]         rel_prev_q;
    logic [1:0]         rel_fall;
    logic [1:0]         sel;
    logic [1:0]         prio;
    logic [1:0]         match;
    logic               auto_mode;
    logic               forced;
    logic               act;
    logic               fwd;
    logic               oth;
    logic               answered;
    logic               timed_out;
    logic               held_now;
    logic [31:0]        status;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 2; p++)
        begin : g_pin
            dps_sync #(.W($bits(dps_port_in_s))) u_sync (
                .clk   (clk),
                .rst_b (rst_b),
                .d     (port_in[p]),
                .q     (pin[p])
            );
        end
    endgenerate

    // drive answer and override switch come from outside too
    dps_sync #(.W(3)) u_sync_misc (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({drv_selected, ovr_sw}),
        .q     ({drv_sel, ovr_raw})
    );

    assign ovr = dps_ovr_e'(ovr_raw);

    // ----------------------------------------------------------------
    // per-port decode and release pulse width check
    // ----------------------------------------------------------------
    generate
        for (p = 0; p < 2; p++)
        begin : g_port
            assign sel[p]   = pin[p].sel_en;
            assign prio[p]  = pin[p].prio;
            assign match[p] = pin[p].addr == plug_q;
            // short glitches on the release line must not drop a reservation
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    rel_cnt_q[p]  <= '0;
                    rel_prev_q[p] <= 1'b0;
                end
                else
                begin
                    rel_prev_q[p] <= pin[p].rel_req;
                    if (!pin[p].rel_req)
                        rel_cnt_q[p] <= '0;
                    else if (rel_cnt_q[p] != CNT_W'(REL_MIN_CYC))
                        rel_cnt_q[p] <= rel_cnt_q[p] + CNT_W'(1);
                end
            end
            // act on the falling edge of a long enough pulse
            assign rel_fall[p] = rel_prev_q[p] & ~pin[p].rel_req
                               & (rel_cnt_q[p] == CNT_W'(REL_MIN_CYC));
        end
    endgenerate

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    assign auto_mode = ovr == OVR_AUTO;
    assign forced    = ovr == OVR_FORCE_A || ovr == OVR_FORCE_B;
    assign oth       = ~cur_q;
    // ignore a stale selected level left over from the last owner
    assign answered  = drv_sel && wait_q >= WT_W'(SETTLE_CYC);
    assign timed_out = wait_q == WT_W'(SEL_WAIT_CYC - 1);
    assign held_now  = st_q == ST_OWNED && sel[oth] && match[oth];

    // state, owner and tie-break memory
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q       <= ST_NEUTRAL;
            cur_q      <= 1'b0;
            last_win_q <= 1'b1;
        end
        else if (!auto_mode)
            st_q <= ST_NEUTRAL;
        else
        begin
            unique case (st_q)
                ST_NEUTRAL:
                    if (sel[0] || sel[1])
                    begin
                        st_q <= ST_TRY;
                        // alternate on a tie so neither port starves
                        cur_q <= (sel[0] && sel[1]) ? ~last_win_q : sel[1];
                    end
                ST_TRY:
                    if (answered)
                    begin
                        st_q       <= ST_OWNED;
                        last_win_q <= cur_q;
                    end
                    else if (!sel[cur_q] || timed_out)
                    begin
                        st_q       <= ST_NEUTRAL;
                        last_win_q <= cur_q;
                    end
                ST_OWNED:
                    if (variant == VAR_STICKY)
                    begin
                        if (rel_fall[cur_q])
                            st_q <= ST_NEUTRAL;
                        else if (rel_fall[oth] && held_now)
                            st_q <= ST_NEUTRAL;
                    end
                    else
                    begin
                        if (!sel[cur_q] && !prio[cur_q])
                            st_q <= ST_NEUTRAL;
                        else if (prio[oth] && !prio[cur_q])
                            st_q <= ST_NEUTRAL;
                    end
            endcase
        end
    end

    // answer wait counter for the provisional reservation
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wait_q <= '0;
        else if (st_q != ST_TRY)
            wait_q <= '0;
        else if (!timed_out)
            wait_q <= wait_q + WT_W'(1);
    end

    // plug register keeps the winning address
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            plug_q <= '0;
        else if (auto_mode && st_q == ST_TRY && answered)
            plug_q <= pin[cur_q].addr;
    end

    // ----------------------------------------------------------------
    // drive and controller outputs
    // ----------------------------------------------------------------
    assign act = forced ? (ovr == OVR_FORCE_B) : cur_q;
    assign fwd = forced || (auto_mode && st_q != ST_NEUTRAL);

    // forwarded address and strobe toward the drive
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drv_addr   <= '0;
            drv_sel_en <= 1'b0;
        end
        else
        begin
            drv_addr   <= fwd ? pin[act].addr : '0;
            drv_sel_en <= fwd && pin[act].sel_en;
        end
    end

    // status lines back to each controller
    generate
        for (p = 0; p < 2; p++)
        begin : g_out
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    port_out[p] <= '0;
                else
                begin
                    port_out[p].selected <= fwd && act == 1'(p) && drv_sel
                        && (forced || st_q == ST_OWNED);
                    port_out[p].held_by_other_port <= auto_mode && held_now
                        && oth == 1'(p);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb
    begin
        status                 = 32'h0000_0000;
        status[STAT_ST +: 2]   = st_q;
        status[STAT_OWN]       = cur_q;
        status[STAT_PLUG +: ADDR_W] = plug_q;
        status[STAT_OVR +: 2]  = ovr;
        status[STAT_HELD]      = held_now;
    end

    dps_ahb_regs u_regs (
        .clk       (clk),
        .rst_b     (rst_b),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .status    (status),
        .variant   (variant)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_FORCE_IGNORE: assert property (
        ovr == OVR_FORCE_A && !sel[0] |=> !drv_sel_en
    ) else $error("forced port strobe not followed");
    AST_MANUAL_NEUTRAL: assert property (
        !auto_mode |=> st_q == ST_NEUTRAL && !port_out[0].held_by_other_port
    ) else $error("dynamic logic active under override");
    AST_NEUTRAL_ACCEPT: assert property (
        auto_mode && st_q == ST_NEUTRAL && (sel[0] || sel[1]) |=> st_q == ST_TRY
    ) else $error("attempt not accepted in neutral");
    AST_BIND_FIRST: assert property (
        auto_mode && st_q == ST_TRY && answered
        |=> st_q == ST_OWNED && cur_q == $past(cur_q)
    ) else $error("owner not bound to selecting port");
    AST_TIE_ALTERNATE: assert property (
        auto_mode && st_q == ST_NEUTRAL && sel[0] && sel[1]
        |=> cur_q == !$past(last_win_q)
    ) else $error("tie not broken by alternation");
    AST_FORWARD: assert property (
        auto_mode && st_q == ST_TRY && $stable(pin) ##1 st_q == ST_TRY
        |-> drv_addr == $past(pin[cur_q].addr)
    ) else $error("address not forwarded");
    AST_MISMATCH_CLEAR: assert property (
        auto_mode && st_q == ST_TRY && timed_out && !answered |=> st_q == ST_NEUTRAL
    ) else $error("provisional reservation not cleared");
    AST_PLUG_STORE: assert property (
        $rose(st_q == ST_OWNED) |-> plug_q == $past(pin[cur_q].addr)
    ) else $error("plug register not loaded");
    AST_HELD_MEANS: assert property (
        port_out[1].held_by_other_port |-> $past(st_q == ST_OWNED && !cur_q && match[1])
    ) else $error("held status without partner ownership");
    AST_STICKY_HOLD: assert property (
        auto_mode && variant == VAR_STICKY && st_q == ST_OWNED && rel_fall == 2'b00
        |=> st_q == ST_OWNED
    ) else $error("sticky reservation lost without release");
    AST_STROBE_DROP: assert property (
        auto_mode && variant == VAR_STROBE && st_q == ST_OWNED
        && !sel[cur_q] && !prio[cur_q] |=> st_q == ST_NEUTRAL
    ) else $error("strobe reservation not released");

    COV_OWNED: cover property (st_q == ST_TRY ##[1:120] st_q == ST_OWNED);
    COV_HELD: cover property (port_out[0].held_by_other_port);
    COV_FORCED_REL: cover property (held_now && rel_fall[oth] ##1 st_q == ST_NEUTRAL);
    COV_TIE: cover property (st_q == ST_NEUTRAL && sel == 2'b11);
endmodule

// file: include/dps_pkg.sv
// constants and types shared by the dual-port reservation switch
package dps_pkg;
    // ----------------------------------------------------------------
    // widths and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W       = 4;
    localparam int CLK_NS       = 10;
    localparam int SEL_WAIT_NS  = 1000;
    localparam int SEL_WAIT_CYC = SEL_WAIT_NS / CLK_NS;
    localparam int REL_MIN_NS   = 1000;
    localparam int REL_MIN_CYC  = (REL_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC   = 4;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] CTRL_OFS  = 12'h000;
    localparam logic [11:0] STAT_OFS  = 12'h004;
    localparam int          CTRL_VAR  = 0;
    localparam logic        CTRL_RST  = 1'h0;
    localparam int          STAT_ST   = 0;
    localparam int          STAT_OWN  = 2;
    localparam int          STAT_PLUG = 4;
    localparam int          STAT_OVR  = 8;
    localparam int          STAT_HELD = 10;
    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {OVR_AUTO, OVR_FORCE_A, OVR_FORCE_B, OVR_SPARE} dps_ovr_e;
    typedef enum logic {VAR_STICKY, VAR_STROBE} dps_variant_e;
    typedef enum logic [1:0] {ST_NEUTRAL, ST_TRY, ST_OWNED} dps_state_e;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              sel_en;
        logic              rel_req;
        logic              prio;
    } dps_port_in_s;
    typedef struct packed {
        logic selected;
        logic held_by_other_port;
    } dps_port_out_s;
endpackage

// file: hw/dps_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ns
module dps_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule

// file: hw/dps_ahb_regs.sv
// ahb-lite slave holding the control and status registers
`timescale 1ns/1ns
module dps_ahb_regs (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [31:0] status,
    output dps_pkg::dps_variant_e variant
);
    import dps_pkg::*;

    logic        wr_q;
    logic [11:0] waddr_q;
    logic        take;

    // zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign take      = hsel & hready & htrans[1] & (hsize == 3'h2);

    // capture write address phase
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q    <= 1'b0;
            waddr_q <= 12'h000;
        end
        else
        begin
            wr_q    <= take & hwrite;
            waddr_q <= haddr[11:0];
        end
    end

    // control register, written in the data phase
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            variant <= dps_variant_e'(CTRL_RST);
        else if (wr_q && waddr_q == CTRL_OFS)
            variant <= dps_variant_e'(hwdata[CTRL_VAR]);
    end

    // read data registered at the address phase; unmapped reads zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
        begin
            if (haddr[11:0] == CTRL_OFS)
                hrdata <= {31'h0, variant};
            else if (haddr[11:0] == STAT_OFS)
                hrdata <= status;
            else
                hrdata <= 32'h0000_0000;
        end
    end
endmodule

// file: verif/dps_drive_model.sv
// behavioural disk drive answering a forwarded select against its plug
`timescale 1ns/1ns
module dps_drive_model #(
    parameter logic [3:0] PLUG = 4'h5
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] drv_addr,
    input  wire logic       drv_sel_en,
    input  wire logic [7:0] lat,
    output logic            drv_selected
);
    // ----------------------------------------
    // plug compare with adjustable answer delay
    // ----------------------------------------
    logic       hit;
    logic [7:0] wait_q;

    assign hit = drv_sel_en && (drv_addr == PLUG);

    // counts cycles of a matching strobe; saturates so a long hold stays selected
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            wait_q <= 8'h00;
        else if (!hit)
            wait_q <= 8'h00;
        else if (wait_q != 8'hff)
            wait_q <= wait_q + 8'h01;
    end

    // answer drops at once with the strobe, as a real drive deselects
    assign drv_selected = hit && (wait_q >= lat);
endmodule

// file: verif/tb_top.sv
// self-checking bench for the dual-port reservation switch
`timescale 1ns/1ns
module tb_top;
    import dps_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    localparam logic [3:0] PLUG = 4'h5;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    dps_port_in_s  [1:0]   pin;
    dps_port_out_s [1:0]   pout;
    logic [1:0]            ovr_sw;
    logic [ADDR_W-1:0]     drv_addr;
    logic                  drv_sel_en;
    logic                  drv_selected;
    logic [7:0]            lat;
    logic                  hsel;
    logic [31:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic [31:0]           hwdata;
    logic                  hreadyout;
    logic                  hresp;
    logic [31:0]           hrdata;
    logic [31:0]           q;
    int                    mismatches = 0;
    int                    checks_done = 0;
    int                    cyc = 0;

    always #5 clk = ~clk;

    dps_switch u_dps_switch (.clk(clk), .rst_b(rst_b), .port_in(pin), .port_out(pout),
        .ovr_sw(ovr_sw), .drv_addr(drv_addr), .drv_sel_en(drv_sel_en),
        .drv_selected(drv_selected), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

    dps_drive_model #(.PLUG(PLUG)) u_dps_drive_model (.clk(clk), .rst_b(rst_b),
        .drv_addr(drv_addr), .drv_sel_en(drv_sel_en), .lat(lat),
        .drv_selected(drv_selected));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task finish_test();
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // hang guard; the whole sequence needs well under two thousand cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            mismatches++;
            finish_test();
        end
    end

    task chk1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // single word transfer; read data taken at the edge ending the data phase
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
        chk1("hresp", 1'b0, hresp);
        chk1("hreadyout", 1'b1, hreadyout);
    endtask

    task rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp,
                input logic [31:0] m);
        ahb(1'b0, a, 32'h0);
        chk32(what, exp & m, q & m);
    endtask

    function logic [31:0] stat(input logic [1:0] st, input logic own, input logic held);
        stat = {30'h0, st} | (32'(own) << STAT_OWN) | (32'(PLUG) << STAT_PLUG)
             | (32'(held) << STAT_HELD);
    endfunction

    task cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // address first, strobe no sooner than 200 ns later
    task attempt(input int p, input logic [3:0] a);
        @(posedge clk);
        pin[p].addr <= a;
        repeat (20) @(posedge clk);
        pin[p].sel_en <= 1'b1;
    endtask

    task drop(input int p);
        @(posedge clk);
        pin[p].sel_en <= 1'b0;
    endtask

    task rel_pulse(input int p, input int n);
        @(posedge clk);
        pin[p].rel_req <= 1'b1;
        repeat (n) @(posedge clk);
        pin[p].rel_req <= 1'b0;
    endtask

    function logic outv(input int p, input bit held);
        outv = held ? pout[p].held_by_other_port : pout[p].selected;
    endfunction

    // bounded wait for a status line, then compare
    task wait_out(input string what, input int p, input bit held, input logic exp,
                  input int lim);
        int n;
        n = 0;
        #1;
        while (outv(p, held) !== exp && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1(what, exp, outv(p, held));
    endtask

    initial
    begin
        pin = '0;
        ovr_sw = 2'h0;
        lat = 8'd10;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        cycles(1);
        chk1("drv_sel_en", 1'b0, drv_sel_en);
        wait_out("sel a", 0, 0, 1'b0, 0);
        rd_chk("status", STAT_OFS, 32'h0, '1);
        rd_chk("unmapped", 32'h10, 32'h0, '1);
        // no answer to a wrong address: attempt gives up
        attempt(0, 4'h3);
        cycles(150);
        wait_out("sel a bad", 0, 0, 1'b0, 0);
        drop(0);
        cycles(10);
        rd_chk("status", STAT_OFS, 32'h0, 32'h3);
        // sticky reservation by port a
        attempt(0, PLUG);
        wait_out("sel a", 0, 0, 1'b1, 60);
        chk32("drv addr", {28'h0, PLUG}, {28'h0, drv_addr});
        rd_chk("status", STAT_OFS, stat(2'h2, 1'b0, 1'b0), '1);
        drop(0);
        cycles(30);
        rd_chk("status", STAT_OFS, stat(2'h2, 1'b0, 1'b0), 32'h7);
        attempt(1, PLUG);
        wait_out("held b", 1, 1, 1'b1, 40);
        wait_out("sel b", 1, 0, 1'b0, 0);
        rel_pulse(1, 50);
        cycles(20);
        wait_out("held b", 1, 1, 1'b1, 0);
        rel_pulse(1, 110);
        wait_out("held b", 1, 1, 1'b0, 20);
        wait_out("sel b", 1, 0, 1'b1, 80);
        drop(1);
        cycles(20);
        rd_chk("status", STAT_OFS, stat(2'h2, 1'b1, 1'b0), 32'h7);
        rel_pulse(1, 110);
        cycles(20);
        rd_chk("status", STAT_OFS, 32'h0, 32'h3);
        // simultaneous strobes with a prompt drive; b won last, so a wins
        lat = 8'd0;
        attempt(1, PLUG);
        pin[0].addr <= PLUG;
        pin[0].sel_en <= 1'b1;
        wait_out("tie a", 0, 0, 1'b1, 40);
        wait_out("tie b", 1, 1, 1'b1, 20);
        @(posedge clk);
        pin <= '0;
        rel_pulse(0, 110);
        cycles(20);
        rd_chk("status", STAT_OFS, 32'h0, 32'h3);
        // strobe-held variant
        lat = 8'd10;
        ahb(1'b1, CTRL_OFS, 32'h1);
        rd_chk("ctrl", CTRL_OFS, 32'h1, 32'h1);
        attempt(0, PLUG);
        wait_out("sel a", 0, 0, 1'b1, 60);
        drop(0);
        wait_out("sel a", 0, 0, 1'b0, 20);
        rd_chk("status", STAT_OFS, 32'h0, 32'h3);
        @(posedge clk);
        pin[0].prio <= 1'b1;
        pin[1].prio <= 1'b1;
        attempt(0, PLUG);
        wait_out("sel a", 0, 0, 1'b1, 60);
        attempt(1, PLUG);
        cycles(40);
        wait_out("sel a", 0, 0, 1'b1, 0);
        @(posedge clk);
        pin[0].prio <= 1'b0;
        wait_out("sel b", 1, 0, 1'b1, 80);
        wait_out("sel a", 0, 0, 1'b0, 0);
        wait_out("held a", 0, 1, 1'b1, 5);
        @(posedge clk);
        pin <= '0;
        cycles(20);
        // manual override: forced port passes straight through
        attempt(0, 4'h7);
        attempt(1, 4'h9);
        ovr_sw <= 2'h1;
        cycles(10);
        chk32("drv addr", 32'h7, {28'h0, drv_addr});
        chk1("drv_sel_en", 1'b1, drv_sel_en);
        rel_pulse(0, 110);
        cycles(10);
        chk32("drv addr", 32'h7, {28'h0, drv_addr});
        @(posedge clk);
        ovr_sw <= 2'h2;
        cycles(10);
        chk32("drv addr", 32'h9, {28'h0, drv_addr});
        rd_chk("status", STAT_OFS, 32'h200, 32'h303);
        @(posedge clk);
        ovr_sw <= 2'h3;
        cycles(10);
        chk1("drv_sel_en", 1'b0, drv_sel_en);
        finish_test();
    end
endmodule
